// ===== logic/dprc_top.v
// What this block does
// R1: Alarm shows its code, then stops or runs per its action.
// R2: Fault shows its code and stops by its action method.
// R3: Overheat sensing only when input two is motor temp.
// R4: Reverse inhibit 1 ignores reverse runs; 0 allows them.
// R5: Inhibit 2 swaps phases; swap variant only, no encoder.
// R6: Mode 1 restarts within ride-through, else UV fault.
// R7: Mode 2 restarts with control power held, no UV fault.
// R8: Mode 0 faults on a loss over 15 ms while running.
// R9: Ride-through is 0 to 2.0 s, default 0.1 s.
// R10: Switching stays off 0.1 to 5.0 s before restart.
// R11: After search, voltage ramps 0 to full in ramp time.
// R12: UV level is 150 to 210 V, doubled for high class.
// R13: Fault outputs are held off in power loss recovery.
// R14: Alarm above 1.17 V; decel, coast, emergency, flash.
// R15: Fault above 2.34 V; decel, coast (default), emergency.
// R16: Temperature is filtered, time constant 0.20 s default.
// R17: Filter is first-order low-pass; thresholds use it.
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ns
`include "dprc_consts.vh"
module dprc_top #(
  parameter TICK_CYC = `DPRC_TICK_CYC,
  parameter SWAP_VARIANT = 1
) (
  // Clock and reset
  input wire CLK_I,
  input wire RST_N_I,
  // AXI4-Lite write
  input wire [7:0] S_AXI_AWADDR_I,
  input wire S_AXI_AWVALID_I,
  output reg S_AXI_AWREADY_O,
  input wire [31:0] S_AXI_WDATA_I,
  input wire [3:0] S_AXI_WSTRB_I,
  input wire S_AXI_WVALID_I,
  output reg S_AXI_WREADY_O,
  output reg [1:0] S_AXI_BRESP_O,
  output reg S_AXI_BVALID_O,
  input wire S_AXI_BREADY_I,
  // AXI4-Lite read
  input wire [7:0] S_AXI_ARADDR_I,
  input wire S_AXI_ARVALID_I,
  output reg S_AXI_ARREADY_O,
  output reg [31:0] S_AXI_RDATA_O,
  output reg [1:0] S_AXI_RRESP_O,
  output reg S_AXI_RVALID_O,
  input wire S_AXI_RREADY_I,
  // Sensed values, same clock
  input wire [11:0] TEMP_CODE_I,
  input wire [9:0] BUS_VOLT_I,
  input wire SEARCH_DONE_I,
  // Pins
  input wire RUN_FWD_I,
  input wire RUN_REV_I,
  input wire CTRL_PWR_OK_I,
  // Drive control
  output reg RUN_O,
  output reg REV_O,
  output reg PHASE_SWAP_O,
  output reg SWITCH_OFF_O,
  output reg [1:0] STOP_MODE_O,
  output reg [9:0] VOLT_SCALE_O,
  output reg SEARCH_REQ_O,
  // Indication
  output reg ALARM_O,
  output reg ALARM_FLASH_O,
  output reg FAULT_O,
  output reg [1:0] ERR_CODE_O,
  output reg IRQ_O
);
  localparam ST_NORM = 3'd0;
  localparam ST_LOSS = 3'd1;
  localparam ST_OFF = 3'd2;
  localparam ST_SRCH = 3'd3;
  localparam ST_RAMP = 3'd4;
  localparam ST_TRIP = 3'd5;

  function [15:0] clampf;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      clampf = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  function [15:0] mergef;
    input [15:0] old;
    input [31:0] d;
    input [3:0] s;
    begin
      mergef = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [2:0] s1_q;
  reg [2:0] s2_q;
  reg [2:0] s3_q;
  reg [2:0] pin_q;
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
      pin_q <= 3'h0;
    end else begin
      s1_q <= {CTRL_PWR_OK_I, RUN_REV_I, RUN_FWD_I};
      s2_q <= s1_q;
      s3_q <= s2_q;
      // A change counts only once two stages agree
      pin_q <= (s2_q & s3_q) | (pin_q & (s2_q ^ s3_q));
    end
  end
  wire fwd = pin_q[0];
  wire rev = pin_q[1];
  wire ctrl_ok = pin_q[2];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [15:0] cfg_q;
  reg [15:0] tfilt_q;
  reg [15:0] ride_q;
  reg [15:0] minoff_q;
  reg [15:0] ramp_q;
  reg [15:0] uvlvl_q;
  reg [4:0] irq_stat_q;
  reg [4:0] irq_en_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg aw_have_q;
  reg w_have_q;
  reg flt_rst_q;
  reg [4:0] irq_clr_q;
  wire [1:0] alm_act = cfg_q[`DPRC_ALM_ACT_LSB +: 2];
  wire [1:0] flt_act = cfg_q[`DPRC_FLT_ACT_LSB +: 2];
  wire [4:0] ai2_sel = cfg_q[`DPRC_AI2_LSB +: 5];
  wire [1:0] rev_sel = cfg_q[`DPRC_REV_LSB +: 2];
  wire [1:0] plm = cfg_q[`DPRC_PLM_LSB +: 2];
  wire wr_go = aw_have_q & w_have_q & ~S_AXI_BVALID_O;
  wire [15:0] wv_cfg = mergef(cfg_q, wdata_q, wstrb_q) & `DPRC_CFG_MASK;

  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      S_AXI_AWREADY_O <= 1'b1;
      S_AXI_WREADY_O <= 1'b1;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= 2'h0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      cfg_q <= `DPRC_CFG_RST;
      tfilt_q <= `DPRC_TFILT_RST;
      ride_q <= `DPRC_RIDE_RST;
      minoff_q <= `DPRC_MINOFF_RST;
      ramp_q <= `DPRC_RAMP_RST;
      uvlvl_q <= `DPRC_UVLVL_RST;
      irq_en_q <= 5'h00;
      flt_rst_q <= 1'b0;
      irq_clr_q <= 5'h00;
    end else begin
      flt_rst_q <= 1'b0;
      irq_clr_q <= 5'h00;
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        awaddr_q <= S_AXI_AWADDR_I;
        aw_have_q <= 1'b1;
        S_AXI_AWREADY_O <= 1'b0;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        wdata_q <= S_AXI_WDATA_I;
        wstrb_q <= S_AXI_WSTRB_I;
        w_have_q <= 1'b1;
        S_AXI_WREADY_O <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O <= 2'h0;
        case ({awaddr_q[7:2], 2'b00})
          `DPRC_CFG_OFS: begin
            // Fault action 3 is not a method; keep coast
            cfg_q <= (wv_cfg[`DPRC_FLT_ACT_LSB +: 2] == 2'h3) ?
                     (wv_cfg & 16'hfff3) | 16'h0004 : wv_cfg; // [R15]
          end
          `DPRC_TFILT_OFS: tfilt_q <= clampf(mergef(tfilt_q, wdata_q,
            wstrb_q), 16'h0000, `DPRC_TFILT_MAX); // [R16]
          `DPRC_RIDE_OFS: ride_q <= clampf(mergef(ride_q, wdata_q,
            wstrb_q), 16'h0000, `DPRC_RIDE_MAX); // [R9]
          `DPRC_MINOFF_OFS: minoff_q <= clampf(mergef(minoff_q, wdata_q,
            wstrb_q), `DPRC_MINOFF_MIN, `DPRC_MINOFF_MAX); // [R10]
          `DPRC_RAMP_OFS: ramp_q <= clampf(mergef(ramp_q, wdata_q,
            wstrb_q), 16'h0000, `DPRC_RAMP_MAX); // [R11]
          `DPRC_UVLVL_OFS: uvlvl_q <= clampf(mergef(uvlvl_q, wdata_q,
            wstrb_q), `DPRC_UVLVL_MIN, `DPRC_UVLVL_MAX); // [R12]
          `DPRC_CMD_OFS: flt_rst_q <= wstrb_q[0] &
            wdata_q[`DPRC_CMD_FLT_RST_BIT];
          `DPRC_IRQ_CLR_OFS: irq_clr_q <= wstrb_q[0] ? wdata_q[4:0] : 5'h00;
          `DPRC_IRQ_EN_OFS: irq_en_q <= wstrb_q[0] ? wdata_q[4:0] : irq_en_q;
          `DPRC_STATUS_OFS, `DPRC_TEMP_OFS, `DPRC_IRQ_STAT_OFS: ;
          default: S_AXI_BRESP_O <= 2'h2;
        endcase
      end
      if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
        S_AXI_AWREADY_O <= 1'b1;
        S_AXI_WREADY_O <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Time base and temperature path
  // ----------------------------------------------------------------
  reg [23:0] tick_cnt_q;
  reg tick_q;
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      tick_cnt_q <= 24'h000000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == TICK_CYC[23:0] - 24'h000001);
      if (tick_cnt_q == TICK_CYC[23:0] - 24'h000001)
        tick_cnt_q <= 24'h000000;
      else
        tick_cnt_q <= tick_cnt_q + 24'h000001;
    end
  end

  wire [11:0] temp_filt;
  dprc_temp_filter #(.W(12)) u_filt (
    .CLK_I(CLK_I),
    .RST_N_I(RST_N_I),
    .tick_i(tick_q),
    .tau_i(tfilt_q),
    .x_i(TEMP_CODE_I),
    .y_o(temp_filt)
  );

  wire oh_en = (ai2_sel == `DPRC_AI2_MOTOR_TEMP); // [R3]
  wire alarm_c = oh_en & (temp_filt > `DPRC_ALARM_CODE); // [R14] [R17]
  wire fault_c = oh_en & (temp_filt > `DPRC_FAULT_CODE); // [R15] [R17]

  // ----------------------------------------------------------------
  // Run command and power loss sequencing
  // ----------------------------------------------------------------
  wire swap_ok = (rev_sel == 2'h2) & (SWAP_VARIANT != 0) &
                 ~cfg_q[`DPRC_ENC_BIT]; // [R5]
  wire rev_ok = rev & ~fwd & (rev_sel != 2'h1); // [R4]
  wire run_req = (fwd & ~rev) | rev_ok;
  wire [10:0] uv_thr = {1'b0, uvlvl_q[9:0]} << cfg_q[`DPRC_HV_BIT]; // [R12]
  wire uv = {1'b0, BUS_VOLT_I} < uv_thr;

  reg [2:0] st_q;
  reg [15:0] off_ms_q;
  reg [15:0] ramp_acc_q;
  reg [9:0] scale_q;
  reg oh_fault_q;
  reg uv_fault_q;
  reg alarm_stop_q;
  reg alarm_d1_q;
  wire [15:0] ride_ms = ride_q * `DPRC_MS_PER_UNIT;
  wire [15:0] minoff_ms = minoff_q * `DPRC_MS_PER_UNIT;
  wire [15:0] ramp_ms = ramp_q * `DPRC_MS_PER_UNIT;
  wire [15:0] ramp_acc_n = ramp_acc_q + (tick_q ? 16'h0400 : 16'h0000);
  wire recov = (st_q == ST_LOSS) | (st_q == ST_OFF) | (st_q == ST_SRCH) |
               (st_q == ST_RAMP);
  wire stop_c = oh_fault_q | uv_fault_q | alarm_stop_q;
  wire drive_on = run_req & ~stop_c & (st_q == ST_NORM | st_q == ST_RAMP);
  wire loss_in = (st_q == ST_NORM) & RUN_O & uv & (plm != `DPRC_PLM_OFF);
  wire uv_trip = ((st_q == ST_NORM) & RUN_O & uv & (plm == `DPRC_PLM_OFF) &
                 (off_ms_q > `DPRC_LOSS_MS)) |
                 ((st_q == ST_LOSS) & (plm == `DPRC_PLM_TIMED) & uv &
                 (off_ms_q > ride_ms));
  wire restart_done = (st_q == ST_RAMP) & (scale_q == `DPRC_RAMP_FULL);

  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      st_q <= ST_NORM;
      off_ms_q <= 16'h0000;
      ramp_acc_q <= 16'h0000;
      scale_q <= `DPRC_RAMP_FULL;
      uv_fault_q <= 1'b0;
    end else begin
      if (tick_q && off_ms_q != 16'hffff)
        off_ms_q <= off_ms_q + 16'h0001;
      case (st_q)
        ST_NORM: begin
          if (!(RUN_O && uv))
            off_ms_q <= 16'h0000;
          if (uv_trip) begin
            st_q <= ST_TRIP; // [R8]
            uv_fault_q <= 1'b1;
          end else if (loss_in) begin
            st_q <= ST_LOSS;
            off_ms_q <= 16'h0000;
          end
        end
        ST_LOSS: begin
          if (!run_req || (plm == `DPRC_PLM_BACKED && !ctrl_ok))
            st_q <= ST_NORM; // [R7]
          else if (uv_trip) begin
            st_q <= ST_TRIP; // [R6]
            uv_fault_q <= 1'b1;
          end else if (!uv)
            st_q <= ST_OFF; // [R6] [R7]
        end
        ST_OFF: begin
          if (!run_req)
            st_q <= ST_NORM;
          else if (uv)
            st_q <= ST_LOSS;
          else if (off_ms_q >= minoff_ms)
            st_q <= ST_SRCH; // [R10]
        end
        ST_SRCH: begin
          ramp_acc_q <= 16'h0000;
          scale_q <= 10'h000;
          if (!run_req)
            st_q <= ST_NORM;
          else if (SEARCH_DONE_I)
            st_q <= ST_RAMP;
        end
        ST_RAMP: begin
          // Carry keeps the slope exact
          if (ramp_acc_n >= ramp_ms) begin
            ramp_acc_q <= ramp_acc_n - ramp_ms;
            scale_q <= scale_q + 10'h001; // [R11]
          end else begin
            ramp_acc_q <= ramp_acc_n;
          end
          if (!run_req || restart_done) begin
            st_q <= ST_NORM;
            scale_q <= `DPRC_RAMP_FULL;
          end
        end
        ST_TRIP: begin
          if (flt_rst_q && !uv) begin
            st_q <= ST_NORM;
            uv_fault_q <= 1'b0;
          end
        end
        default: st_q <= ST_NORM;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Overheat latches and outputs
  // ----------------------------------------------------------------
  wire [4:0] ev = {restart_done, uv_trip, loss_in,
                   fault_c & ~oh_fault_q, alarm_c & ~alarm_d1_q};
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      oh_fault_q <= 1'b0;
      alarm_stop_q <= 1'b0;
      alarm_d1_q <= 1'b0;
      irq_stat_q <= 5'h00;
      IRQ_O <= 1'b0;
      RUN_O <= 1'b0;
      REV_O <= 1'b0;
      PHASE_SWAP_O <= 1'b0;
      SWITCH_OFF_O <= 1'b1;
      STOP_MODE_O <= `DPRC_STOP_DECEL;
      VOLT_SCALE_O <= `DPRC_RAMP_FULL;
      SEARCH_REQ_O <= 1'b0;
      ALARM_O <= 1'b0;
      ALARM_FLASH_O <= 1'b0;
      FAULT_O <= 1'b0;
      ERR_CODE_O <= `DPRC_ERR_NONE;
    end else begin
      alarm_d1_q <= alarm_c;
      // Set wins over a clear in the same cycle
      oh_fault_q <= fault_c | (oh_fault_q & ~flt_rst_q); // [R2] [R15]
      alarm_stop_q <= (alarm_c & (alm_act != `DPRC_ALM_CONTINUE) & RUN_O) |
                      (alarm_stop_q & (run_req | alarm_c)); // [R1]
      irq_stat_q <= ev | (irq_stat_q & ~irq_clr_q);
      IRQ_O <= |(irq_stat_q & irq_en_q);
      RUN_O <= drive_on;
      REV_O <= rev_ok;
      PHASE_SWAP_O <= swap_ok; // [R5]
      SWITCH_OFF_O <= ~drive_on; // [R10]
      if (oh_fault_q)
        STOP_MODE_O <= flt_act; // [R2]
      else if (alarm_stop_q)
        STOP_MODE_O <= alm_act; // [R1] [R14]
      else if (uv_fault_q)
        STOP_MODE_O <= `DPRC_STOP_COAST;
      else
        STOP_MODE_O <= `DPRC_STOP_DECEL;
      VOLT_SCALE_O <= scale_q;
      SEARCH_REQ_O <= (st_q == ST_SRCH);
      ALARM_O <= alarm_c & ~recov;
      ALARM_FLASH_O <= alarm_c & (alm_act == `DPRC_ALM_CONTINUE); // [R14]
      FAULT_O <= (oh_fault_q | uv_fault_q) & ~recov; // [R13]
      if (recov)
        ERR_CODE_O <= `DPRC_ERR_NONE; // [R13]
      else if (uv_fault_q)
        ERR_CODE_O <= `DPRC_ERR_UV;
      else if (oh_fault_q)
        ERR_CODE_O <= `DPRC_ERR_OH_FAULT; // [R2]
      else if (alarm_c)
        ERR_CODE_O <= `DPRC_ERR_OH_ALARM; // [R1]
      else
        ERR_CODE_O <= `DPRC_ERR_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      S_AXI_ARREADY_O <= 1'b1;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h00000000;
      S_AXI_RRESP_O <= 2'h0;
    end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RRESP_O <= 2'h0;
      case ({S_AXI_ARADDR_I[7:2], 2'b00})
        `DPRC_CFG_OFS: S_AXI_RDATA_O <= {16'h0000, cfg_q};
        `DPRC_TFILT_OFS: S_AXI_RDATA_O <= {16'h0000, tfilt_q};
        `DPRC_RIDE_OFS: S_AXI_RDATA_O <= {16'h0000, ride_q};
        `DPRC_MINOFF_OFS: S_AXI_RDATA_O <= {16'h0000, minoff_q};
        `DPRC_RAMP_OFS: S_AXI_RDATA_O <= {16'h0000, ramp_q};
        `DPRC_UVLVL_OFS: S_AXI_RDATA_O <= {16'h0000, uvlvl_q};
        `DPRC_STATUS_OFS: S_AXI_RDATA_O <= {20'h00000, st_q, ctrl_ok, uv,
          uv_fault_q, oh_fault_q, alarm_c, SWITCH_OFF_O, PHASE_SWAP_O,
          REV_O, RUN_O};
        `DPRC_TEMP_OFS: S_AXI_RDATA_O <= {20'h00000, temp_filt};
        `DPRC_IRQ_STAT_OFS: S_AXI_RDATA_O <= {27'h0000000, irq_stat_q};
        `DPRC_IRQ_EN_OFS: S_AXI_RDATA_O <= {27'h0000000, irq_en_q};
        `DPRC_CMD_OFS, `DPRC_IRQ_CLR_OFS: S_AXI_RDATA_O <= 32'h00000000;
        default: begin
          S_AXI_RDATA_O <= 32'h00000000;
          S_AXI_RRESP_O <= 2'h2;
        end
      endcase
    end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_ARREADY_O <= 1'b1;
    end
  end
endmodule

// ===== logic/dprc_consts.vh
`ifndef DPRC_CONSTS_VH
`define DPRC_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DPRC_CFG_OFS 8'h00
`define DPRC_TFILT_OFS 8'h04
`define DPRC_RIDE_OFS 8'h08
`define DPRC_MINOFF_OFS 8'h0c
`define DPRC_RAMP_OFS 8'h10
`define DPRC_UVLVL_OFS 8'h14
`define DPRC_CMD_OFS 8'h18
`define DPRC_STATUS_OFS 8'h1c
`define DPRC_TEMP_OFS 8'h20
`define DPRC_IRQ_STAT_OFS 8'h24
`define DPRC_IRQ_CLR_OFS 8'h28
`define DPRC_IRQ_EN_OFS 8'h2c

// ----------------------------------------------------------------
// Configuration word fields
// ----------------------------------------------------------------
`define DPRC_ALM_ACT_LSB 0
`define DPRC_FLT_ACT_LSB 2
`define DPRC_AI2_LSB 4
`define DPRC_REV_LSB 9
`define DPRC_PLM_LSB 11
`define DPRC_HV_BIT 13
`define DPRC_ENC_BIT 14
`define DPRC_CFG_MASK 16'h7fff
`define DPRC_CMD_FLT_RST_BIT 0

// ----------------------------------------------------------------
// Reset values and ranges (filter in 10 ms units, UV level in volts, others 0.1 s)
// ----------------------------------------------------------------
`define DPRC_CFG_RST 16'h01f7
`define DPRC_TFILT_RST 16'h0014
`define DPRC_RIDE_RST 16'h0001
`define DPRC_MINOFF_RST 16'h0001
`define DPRC_RAMP_RST 16'h0003
`define DPRC_UVLVL_RST 16'h0096
`define DPRC_TFILT_MAX 16'h03e8
`define DPRC_RIDE_MAX 16'h0014
`define DPRC_MINOFF_MIN 16'h0001
`define DPRC_MINOFF_MAX 16'h0032
`define DPRC_RAMP_MAX 16'h0032
`define DPRC_UVLVL_MIN 16'h0096
`define DPRC_UVLVL_MAX 16'h00d2

// ----------------------------------------------------------------
// Codes
// ----------------------------------------------------------------
`define DPRC_AI2_MOTOR_TEMP 5'h0e
`define DPRC_STOP_DECEL 2'h0
`define DPRC_STOP_COAST 2'h1
`define DPRC_ALM_CONTINUE 2'h3
`define DPRC_PLM_OFF 2'h0
`define DPRC_PLM_TIMED 2'h1
`define DPRC_PLM_BACKED 2'h2
`define DPRC_ERR_NONE 2'h0
`define DPRC_ERR_OH_ALARM 2'h1
`define DPRC_ERR_OH_FAULT 2'h2
`define DPRC_ERR_UV 2'h3

// ----------------------------------------------------------------
// Timing and analog scaling
// ----------------------------------------------------------------
`define DPRC_CLK_HZ 20000000
`define DPRC_TICK_US 1000
`define DPRC_TICK_CYC (`DPRC_CLK_HZ / 1000000 * `DPRC_TICK_US)
`define DPRC_LOSS_MS 15
`define DPRC_MS_PER_UNIT 16'd100
`define DPRC_ADC_FS_MV 10000
`define DPRC_ALARM_MV 1170
`define DPRC_FAULT_MV 2340
`define DPRC_ALARM_CODE (`DPRC_ALARM_MV * 4096 / `DPRC_ADC_FS_MV)
`define DPRC_FAULT_CODE (`DPRC_FAULT_MV * 4096 / `DPRC_ADC_FS_MV)
`define DPRC_RAMP_FULL 10'h3ff

`endif

// ===== logic/dprc_temp_filter.v
`timescale 1ns/1ns
module dprc_temp_filter #(
  parameter W = 12
) (
  // Clock and reset
  input wire CLK_I,
  input wire RST_N_I,
  // Control
  input wire tick_i,
  input wire [15:0] tau_i,
  // Data
  input wire [W-1:0] x_i,
  output wire [W-1:0] y_o
);
  // ----------------------------------------------------------------
  // First-order low-pass, gain 1/16 per step
  // ----------------------------------------------------------------
  // 16 steps span tau; the tick remainder carries over
  reg [W+3:0] y_q;
  reg [19:0] acc_q;
  wire [19:0] tau_ms = tau_i * 20'd10;
  wire [19:0] acc_n = acc_q + 20'd16;
  wire signed [W+5:0] diff = $signed({2'b00, x_i, 4'h0}) -
                              $signed({2'b00, y_q});

  assign y_o = y_q[W+3:4];

  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      y_q <= {(W+4){1'b0}};
      acc_q <= 20'h00000;
    end else if (tau_i == 16'h0000) begin
      y_q <= {x_i, 4'h0}; // [R16]
      acc_q <= 20'h00000;
    end else if (tick_i) begin
      if (acc_n >= tau_ms) begin
        acc_q <= acc_n - tau_ms;
        y_q <= y_q + {{4{diff[W+5]}}, diff[W+3:4]}; // [R17]
      end else begin
        acc_q <= acc_n;
      end
    end
  end
endmodule

// ===== tb/dprc_chk_assertions.sv
`timescale 1ns/1ns
module dprc_chk #(
  parameter TICK_CYC = 20000
) (
  // Clock and reset
  input wire CLK_I,
  input wire RST_N_I,
  // Drive and indication
  input wire SEARCH_REQ_O,
  input wire SWITCH_OFF_O,
  input wire RUN_O,
  input wire [1:0] STOP_MODE_O,
  input wire [9:0] VOLT_SCALE_O,
  input wire ALARM_O,
  input wire FAULT_O,
  input wire [1:0] ERR_CODE_O
);
  // One tick of slack: off time counts ticks
  localparam int OFF_MIN = 99 * TICK_CYC;
  int unsigned off_q;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  always @(posedge CLK_I) begin
    off_q <= (!RST_N_I || !SWITCH_OFF_O) ? 0 : off_q + 1;
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  AST_FLT_CODE: assert property (FAULT_O |-> ERR_CODE_O[1])
    else $error("fault without fault code");
  AST_ALM_CODE: assert property (ALARM_O |-> ERR_CODE_O != 2'h0)
    else $error("alarm without code");
  AST_RECOV_FLT: assert property (SEARCH_REQ_O |-> !FAULT_O)
    else $error("fault shown in recovery");
  AST_RECOV_ALM: assert property (SEARCH_REQ_O |-> !ALARM_O)
    else $error("alarm shown in recovery");
  AST_MIN_OFF: assert property ($rose(SEARCH_REQ_O) |->
    off_q >= OFF_MIN) else $error("restart before minimum off time");
  AST_RAMP_UP: assert property (
    !SWITCH_OFF_O && VOLT_SCALE_O != 10'h3ff |=>
    SWITCH_OFF_O || VOLT_SCALE_O >= $past(VOLT_SCALE_O))
    else $error("voltage ramp went down");
  AST_FLT_STOP: assert property (
    $rose(FAULT_O) && ERR_CODE_O == 2'h2 && $past(RUN_O) |->
    ##[0:8] !RUN_O) else $error("overheat fault kept running");
  AST_UV_COAST: assert property (
    $rose(FAULT_O) && ERR_CODE_O == 2'h3 && $past(RUN_O) |->
    ##[0:1] STOP_MODE_O == 2'h1) else $error("undervoltage not coast");
endmodule
bind dprc_top dprc_chk #(.TICK_CYC(TICK_CYC)) u_chk (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .SEARCH_REQ_O(SEARCH_REQ_O),
  .SWITCH_OFF_O(SWITCH_OFF_O), .RUN_O(RUN_O), .STOP_MODE_O(STOP_MODE_O),
  .VOLT_SCALE_O(VOLT_SCALE_O), .ALARM_O(ALARM_O), .FAULT_O(FAULT_O),
  .ERR_CODE_O(ERR_CODE_O));

// ===== tb/dprc_env.sv
`timescale 1ns/1ns
module dprc_env (
  // Clock
  input wire logic clk_i,
  // Scenario controls
  input wire logic mains_i,
  // Drive side
  input wire logic search_req_i,
  output logic [9:0] bus_volt_o,
  output logic search_done_o
);
  logic [5:0] cnt_q = 6'h00;
  initial search_done_o = 1'h0;
  // ------------------------------------------------------------
  // Mains and motor
  // ------------------------------------------------------------
  // Lost supply sags under any level
  assign bus_volt_o = mains_i ? 10'h118 : 10'h028;
  // Search reports done after a spin-up
  always @(posedge clk_i) begin
    cnt_q <= search_req_i ? cnt_q + 6'h01 : 6'h00;
    search_done_o <= search_req_i && cnt_q == 6'h28;
  end
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ns
`include "dprc_consts.vh"
module tb;
  logic clk = 1'h0, rst_n = 1'h0, mains = 1'h1, fwd = 1'h0, rev = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, ctrl = 1'h1;
  logic arvalid = 1'h0, rready = 1'h0;
  logic [11:0] temp = 12'h000;
  logic awready, wready, bvalid, arready, rvalid, srch_done, srch_req;
  logic [1:0] bresp, rresp, stop_mode, err;
  logic [9:0] bus_volt, volt;
  logic run, rev_o, swap, sw_off, alarm, flash, fault, irq;
  int fails = 0, cmp_count = 0, n;
  logic [31:0] cfg[4] = '{32'h1f7, 32'h3f7, 32'h5f7, 32'h45f7};
  logic [2:0] rexp[4] = '{3'h6, 3'h0, 3'h7, 3'h6};
  dprc_top #(.TICK_CYC(20)) uut (
    .CLK_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready), .TEMP_CODE_I(temp),
    .BUS_VOLT_I(bus_volt), .SEARCH_DONE_I(srch_done), .RUN_FWD_I(fwd),
    .RUN_REV_I(rev), .CTRL_PWR_OK_I(ctrl), .RUN_O(run), .REV_O(rev_o),
    .PHASE_SWAP_O(swap), .SWITCH_OFF_O(sw_off), .STOP_MODE_O(stop_mode),
    .VOLT_SCALE_O(volt), .SEARCH_REQ_O(srch_req), .ALARM_O(alarm),
    .ALARM_FLASH_O(flash), .FAULT_O(fault), .ERR_CODE_O(err),
    .IRQ_O(irq));
  dprc_env env (.clk_i(clk), .mains_i(mains),
    .search_req_i(srch_req),
    .bus_volt_o(bus_volt), .search_done_o(srch_done));
  // ------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------
  initial forever #25 clk = ~clk;
  task wt(input int c);
    repeat (c) @(posedge clk);
  endtask
  task chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge clk);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge clk);
    bready <= 1'h0;
    chk(bresp, e);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'h0;
    while (!rvalid) @(posedge clk);
    rready <= 1'h0;
    chk(rdata, x);
    chk(rresp, e);
  endtask
  // Ramp cycles after search
  task restart;
    while (!srch_req) @(posedge clk);
    while (srch_req) @(posedge clk);
    n = 0;
    while (volt !== `DPRC_RAMP_FULL) begin
      @(posedge clk);
      n++;
    end
  endtask
  task clear_fault;
    mains <= 1'h1;
    fwd <= 1'h0;
    wt(10);
    wr(`DPRC_CMD_OFS, 32'h1, 2'h0);
    wt(4);
  endtask
  task finish_test;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    wt(60000);
    fails++;
    finish_test;
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    wt(5);
    rst_n <= 1'h1;
    wt(4);
    rd(`DPRC_CFG_OFS, `DPRC_CFG_RST, 2'h0);
    rd(`DPRC_TFILT_OFS, `DPRC_TFILT_RST, 2'h0);
    rd(`DPRC_RIDE_OFS, `DPRC_RIDE_RST, 2'h0);
    rd(`DPRC_MINOFF_OFS, `DPRC_MINOFF_RST, 2'h0);
    rd(`DPRC_RAMP_OFS, `DPRC_RAMP_RST, 2'h0);
    rd(`DPRC_UVLVL_OFS, `DPRC_UVLVL_RST, 2'h0);
    rd(8'h40, 32'h0, 2'h2);
    wr(8'h40, 32'h1, 2'h2);
    wr(`DPRC_RIDE_OFS, 32'h64, 2'h0);
    rd(`DPRC_RIDE_OFS, `DPRC_RIDE_MAX, 2'h0);
    wr(`DPRC_RIDE_OFS, 32'h1, 2'h0);
    wr(`DPRC_UVLVL_OFS, 32'hff, 2'h0);
    rd(`DPRC_UVLVL_OFS, `DPRC_UVLVL_MAX, 2'h0);
    wr(`DPRC_UVLVL_OFS, 32'h96, 2'h0);
    wr(`DPRC_IRQ_EN_OFS, 32'h1f, 2'h0);
    wr(`DPRC_TFILT_OFS, 32'h0, 2'h0);
    $display("test registers done");
    fwd <= 1'h1;
    temp <= 12'h3e8;
    wt(10);
    chk({run, alarm, fault}, 3'h4);
    for (int i = 0; i < 4; i++) begin
      temp <= 12'h000;
      fwd <= 1'h1;
      wr(`DPRC_CFG_OFS, 32'he0 | i | (i % 3) << 2, 2'h0);
      wt(10);
      temp <= 12'h1f4;
      wt(10);
      if (i < 3) chk({run, flash, stop_mode, err}, 6'(4 * i + 1));
      else chk({run, flash, err}, 4'hd);
      temp <= 12'h3e8;
      wt(10);
      chk({run, fault, stop_mode, err}, {2'h1, 2'(i % 3), 2'h2});
      temp <= 12'h000;
      clear_fault;
      chk({fault, alarm, err}, 4'h0);
    end
    chk(irq, 1'h1);
    wr(`DPRC_IRQ_EN_OFS, 32'h0, 2'h0);
    wt(2);
    chk(irq, 1'h0);
    wr(`DPRC_IRQ_EN_OFS, 32'h1f, 2'h0);
    wr(`DPRC_IRQ_CLR_OFS, 32'h3, 2'h0);
    wt(2);
    chk(irq, 1'h0);
    rd(`DPRC_IRQ_STAT_OFS, 32'h0, 2'h0);
    $display("test overheat done");
    for (int i = 0; i < 4; i++) begin
      wr(`DPRC_CFG_OFS, cfg[i], 2'h0);
      rev <= 1'h1;
      wt(10);
      chk({run, rev_o, swap}, rexp[i]);
      rev <= 1'h0;
      wt(10);
    end
    $display("test reverse done");
    wr(`DPRC_CFG_OFS, 32'h1f7, 2'h0);
    fwd <= 1'h1;
    wt(10);
    mains <= 1'h0;
    wt(280);
    chk({fault, err}, 3'h0);
    wt(120);
    chk({run, fault, err}, 4'h7);
    clear_fault;
    chk(fault, 1'h0);
    $display("test mode0 done");
    wr(`DPRC_CFG_OFS, 32'h9f7, 2'h0);
    fwd <= 1'h1;
    wt(10);
    mains <= 1'h0;
    wt(1000);
    chk({sw_off, fault, alarm}, 3'h4);
    mains <= 1'h1;
    wt(10);
    chk(srch_req, 1'h0);
    restart;
    chk(n > 5900 && n < 6100, 1'h1);
    chk({run, fault}, 2'h2);
    mains <= 1'h0;
    wt(2200);
    chk({fault, err}, 3'h7);
    clear_fault;
    $display("test mode1 done");
    wr(`DPRC_CFG_OFS, 32'h11f7, 2'h0);
    fwd <= 1'h1;
    wt(10);
    mains <= 1'h0;
    wt(3000);
    chk({fault, err}, 3'h0);
    mains <= 1'h1;
    restart;
    chk({run, fault}, 2'h2);
    ctrl <= 1'h0;
    mains <= 1'h0;
    wt(100);
    chk({fault, err}, 3'h0);
    $display("test mode2 done");
    finish_test;
  end
endmodule
